// ===== design/dgtu_pkg.sv
// Constants shared by the dual group timer unit
package dgtu_pkg;
	localparam int NUM_TMR = 5;
	localparam int AUX_LOW = 0;
	localparam int CORE = 1;
	localparam int AUX_HIGH = 2;
	localparam int G2_AUX = 3;
	localparam int G2_CORE = 4;
	// Prescaler base as log2 of cycles per count
	localparam logic [3:0] G1_BASE_LG = 4'h2;
	localparam logic [3:0] G2_BASE_LG = 4'h1;
	// Register byte offsets
	localparam logic [7:0] OFS_TMR_BASE = 8'h00;
	localparam logic [7:0] OFS_CAPTURE_RELOAD_REG = 8'h14;
	localparam logic [7:0] OFS_CTRL_BASE = 8'h18;
	localparam logic [7:0] OFS_FLAG = 8'h2C;
	localparam logic [7:0] OFS_STAT = 8'h30;
	// Control field positions
	localparam int F_PRESC = 0;
	localparam int F_MODE = 3;
	localparam int F_RUN = 5;
	localparam int F_DOWN = 6;
	localparam int F_EXTDIR = 7;
	localparam int F_EDGE = 8;
	localparam int F_ROLE = 10;
	localparam int F_OE = 10;
	localparam int F_CLR = 10;
	localparam int F_RELSEL = 11;
	localparam int F_LATCLK = 12;
	localparam int F_TRIG = 13;
	// Operating modes
	localparam logic [1:0] M_TIMER = 2'h0;
	localparam logic [1:0] M_GATED = 2'h1;
	localparam logic [1:0] M_COUNT = 2'h2;
	localparam logic [1:0] M_INCR = 2'h3;
	// Reset values, counter maximum and capture flag bit
	localparam logic [15:0] TMR_RST = 16'h0000;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [5:0] FLAG_RST = 6'h00;
	localparam logic [15:0] PRESC_RST = 16'h0000;
	localparam logic [15:0] TMR_MAX = 16'hFFFF;
	localparam int FLAG_CAP = 5;
endpackage : dgtu_pkg

// ===== design/dgtu_top.sv
// Dual group timer unit with classic Wishbone register slave
`timescale 1ns/1ps
`default_nettype none
module dgtu_top (
	input  wire logic        sys_clk_in,
	input  wire logic        reset_n_in,
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [7:0]  wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic      [31:0] wb_dat_out,
	output logic             wb_ack_out,
	input  wire logic [4:0]  timer_input_pin_in,
	input  wire logic [3:0]  direction_input_pin_in,
	input  wire logic        capture_input_pin_in,
	output logic             core_toggle_output_out,
	output logic             group_two_toggle_output_out,
	output logic             group_two_wrap_clock_out
);
	logic [15:0] tmr_reg [0:4];
	logic [15:0] ctrl_reg [0:4];
	logic [15:0] cap_reg;
	logic [5:0]  flag_reg;
	logic        core_latch_reg;
	logic        g2_latch_reg;
	logic [15:0] presc_reg;
	logic [9:0]  syn1_reg;
	logic [9:0]  syn2_reg;
	logic [9:0]  syn3_reg;
	logic        ack_reg;
	logic [31:0] rdat_reg;
	logic        core_out_reg;
	logic        g2_out_reg;
	logic        wrap_out_reg;
	logic [4:0]  cnt_en;
	logic [4:0]  up;
	logic [4:0]  wrap;
	logic [4:0]  tick;
	logic [4:0]  tin_lvl;
	logic [4:0]  tin_rise;
	logic [4:0]  tin_fall;
	logic [4:0]  dir_lvl;
	logic [4:0]  dir_rise;
	logic [4:0]  dir_fall;
	logic        cap_rise;
	logic        cap_fall;
	logic [1:0]  aux_cap;
	logic [1:0]  aux_rel;
	logic        g2_cap;
	logic        g2_rel;
	logic        req;
	logic        wr;
	logic [4:0]  wr_tmr;
	logic [4:0]  wr_ctrl;
	logic        wr_cap;
	logic        wr_flag;

	function automatic logic presc_tick(input logic [15:0] cnt, input logic [3:0] lg);
		logic [15:0] mask;
		mask = (16'h0001 << lg) - 16'h0001;
		return (cnt & mask) == 16'h0000;
	endfunction : presc_tick

	function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
		return (sel[0] & r) | (sel[1] & f);
	endfunction : edge_hit

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
			input logic [3:0] sel);
		logic [15:0] v;
		v = old;
		if (sel[0]) begin
			v[7:0] = d[7:0];
		end
		if (sel[1]) begin
			v[15:8] = d[15:8];
		end
		return v;
	endfunction : merge

	// Pin synchronisers and edge history
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			syn1_reg <= 10'h000;
			syn2_reg <= 10'h000;
			syn3_reg <= 10'h000;
		end else begin
			syn1_reg <= {capture_input_pin_in, direction_input_pin_in, timer_input_pin_in};
			syn2_reg <= syn1_reg;
			syn3_reg <= syn2_reg;
		end
	end

	always_comb begin
		tin_lvl = syn2_reg[4:0];
		tin_rise = syn2_reg[4:0] & ~syn3_reg[4:0];
		tin_fall = ~syn2_reg[4:0] & syn3_reg[4:0];
		// Group two aux timer gets no direction pin
		dir_lvl = {syn2_reg[8], 1'b0, syn2_reg[7:5]};
		dir_rise = {syn2_reg[8] & ~syn3_reg[8], 1'b0, syn2_reg[7:5] & ~syn3_reg[7:5]};
		dir_fall = {~syn2_reg[8] & syn3_reg[8], 1'b0, ~syn2_reg[7:5] & syn3_reg[7:5]};
		cap_rise = syn2_reg[9] & ~syn3_reg[9];
		cap_fall = ~syn2_reg[9] & syn3_reg[9];
	end

	// Free running prescaler
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			presc_reg <= dgtu_pkg::PRESC_RST;
		end else begin
			presc_reg <= presc_reg + 16'h0001;
		end
	end

	// Count enables, direction and wrap detection
	always_comb begin
		logic [1:0] md;
		logic [3:0] lg;
		logic       ae;
		logic       be;
		logic       lat_evt;
		md = 2'h0;
		lg = 4'h0;
		ae = 1'b0;
		be = 1'b0;
		lat_evt = 1'b0;
		wrap = 5'h00;
		for (int i = 0; i < dgtu_pkg::NUM_TMR; i++) begin
			md = ctrl_reg[i][dgtu_pkg::F_MODE +: 2];
			lg = ((i < 3) ? dgtu_pkg::G1_BASE_LG : dgtu_pkg::G2_BASE_LG)
				+ {1'b0, ctrl_reg[i][dgtu_pkg::F_PRESC +: 3]};
			tick[i] = presc_tick(presc_reg, lg);
			up[i] = ctrl_reg[i][dgtu_pkg::F_EXTDIR] ? ~dir_lvl[i]
				: ~ctrl_reg[i][dgtu_pkg::F_DOWN];
			ae = tin_rise[i] | tin_fall[i];
			be = dir_rise[i] | dir_fall[i];
			case (md)
				dgtu_pkg::M_TIMER: cnt_en[i] = tick[i];
				dgtu_pkg::M_GATED: cnt_en[i] = tick[i]
					& (tin_lvl[i] == ctrl_reg[i][dgtu_pkg::F_EDGE]);
				dgtu_pkg::M_COUNT: cnt_en[i] = edge_hit(ctrl_reg[i][dgtu_pkg::F_EDGE +: 2],
					tin_rise[i], tin_fall[i]);
				default: begin
					// Quadrature decode, group two treats this as counter
					if (i < 3) begin
						cnt_en[i] = ae ^ be;
						up[i] = ae ? (tin_lvl[i] != dir_lvl[i])
							: (tin_lvl[i] == dir_lvl[i]);
					end else begin
						cnt_en[i] = edge_hit(ctrl_reg[i][dgtu_pkg::F_EDGE +: 2],
							tin_rise[i], tin_fall[i]);
					end
				end
			endcase
			cnt_en[i] = cnt_en[i] & ctrl_reg[i][dgtu_pkg::F_RUN];
		end
		for (int i = 0; i < dgtu_pkg::NUM_TMR; i++) begin
			if (i == dgtu_pkg::CORE || i == dgtu_pkg::G2_CORE) begin
				wrap[i] = cnt_en[i] & (up[i] ? (tmr_reg[i] == dgtu_pkg::TMR_MAX)
					: (tmr_reg[i] == 16'h0000));
			end
		end
		for (int i = 0; i < dgtu_pkg::NUM_TMR; i++) begin
			if (i != dgtu_pkg::CORE && i != dgtu_pkg::G2_CORE) begin
				lat_evt = (i == dgtu_pkg::G2_AUX) ? wrap[dgtu_pkg::G2_CORE]
					: wrap[dgtu_pkg::CORE];
				// Chained counting from the partner toggle latch
				if (ctrl_reg[i][dgtu_pkg::F_LATCLK]
					&& ctrl_reg[i][dgtu_pkg::F_MODE +: 2] == dgtu_pkg::M_COUNT) begin
					cnt_en[i] = ctrl_reg[i][dgtu_pkg::F_RUN] & lat_evt;
				end
				if (i != dgtu_pkg::G2_AUX && ctrl_reg[i][dgtu_pkg::F_ROLE]) begin
					cnt_en[i] = 1'b0;
				end
				wrap[i] = cnt_en[i] & (up[i] ? (tmr_reg[i] == dgtu_pkg::TMR_MAX)
					: (tmr_reg[i] == 16'h0000));
			end
		end
	end

	// Auxiliary capture and reload triggers
	always_comb begin
		logic [15:0] c;
		logic        lt;
		c = 16'h0000;
		lt = 1'b0;
		for (int k = 0; k < 2; k++) begin
			c = ctrl_reg[2 * k];
			case (c[dgtu_pkg::F_TRIG +: 2])
				2'h0: lt = edge_hit(c[dgtu_pkg::F_EDGE +: 2], tin_rise[2 * k], tin_fall[2 * k]);
				2'h1: lt = wrap[dgtu_pkg::CORE] & ~core_latch_reg;
				2'h2: lt = wrap[dgtu_pkg::CORE] & core_latch_reg;
				default: lt = wrap[dgtu_pkg::CORE];
			endcase
			aux_cap[k] = c[dgtu_pkg::F_ROLE] & ~c[dgtu_pkg::F_RELSEL]
				& edge_hit(c[dgtu_pkg::F_EDGE +: 2], tin_rise[2 * k], tin_fall[2 * k]);
			aux_rel[k] = c[dgtu_pkg::F_ROLE] & c[dgtu_pkg::F_RELSEL] & lt;
		end
	end

	// Group two capture source and reload on wrap
	always_comb begin
		logic [1:0] es;
		logic       cp;
		logic       ci;
		logic       cd;
		es = ctrl_reg[dgtu_pkg::G2_AUX][dgtu_pkg::F_EDGE +: 2];
		cp = edge_hit(es, cap_rise, cap_fall);
		ci = edge_hit(es, tin_rise[dgtu_pkg::CORE], tin_fall[dgtu_pkg::CORE]);
		cd = edge_hit(es, dir_rise[dgtu_pkg::CORE], dir_fall[dgtu_pkg::CORE]);
		case (ctrl_reg[dgtu_pkg::G2_AUX][dgtu_pkg::F_TRIG +: 2])
			2'h0: g2_cap = cp;
			2'h1: g2_cap = ci;
			2'h2: g2_cap = cd;
			default: g2_cap = ci | cd;
		endcase
		g2_rel = wrap[dgtu_pkg::G2_CORE]
			& ctrl_reg[dgtu_pkg::G2_CORE][dgtu_pkg::F_RELSEL];
	end

	// Bus decode
	always_comb begin
		req = wb_cyc_in & wb_stb_in & ~ack_reg;
		wr = req & wb_we_in;
		for (int i = 0; i < dgtu_pkg::NUM_TMR; i++) begin
			wr_tmr[i] = wr & (wb_adr_in == dgtu_pkg::OFS_TMR_BASE + 8'(4 * i));
			wr_ctrl[i] = wr & (wb_adr_in == dgtu_pkg::OFS_CTRL_BASE + 8'(4 * i));
		end
		wr_cap = wr & (wb_adr_in == dgtu_pkg::OFS_CAPTURE_RELOAD_REG);
		wr_flag = wr & (wb_adr_in == dgtu_pkg::OFS_FLAG);
	end

	// Timer counters with capture, reload and bus writes
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			for (int i = 0; i < dgtu_pkg::NUM_TMR; i++) begin
				tmr_reg[i] <= dgtu_pkg::TMR_RST;
			end
		end else begin
			for (int i = 0; i < dgtu_pkg::NUM_TMR; i++) begin
				if (cnt_en[i]) begin
					tmr_reg[i] <= up[i] ? tmr_reg[i] + 16'h0001 : tmr_reg[i] - 16'h0001;
				end
			end
			for (int k = 0; k < 2; k++) begin
				if (aux_cap[k]) begin
					tmr_reg[2 * k] <= tmr_reg[dgtu_pkg::CORE];
				end
			end
			if (aux_rel[0]) begin
				tmr_reg[dgtu_pkg::CORE] <= tmr_reg[dgtu_pkg::AUX_LOW];
			end else if (aux_rel[1]) begin
				tmr_reg[dgtu_pkg::CORE] <= tmr_reg[dgtu_pkg::AUX_HIGH];
			end
			if (g2_rel) begin
				tmr_reg[dgtu_pkg::G2_CORE] <= cap_reg;
			end
			if (g2_cap && ctrl_reg[dgtu_pkg::G2_AUX][dgtu_pkg::F_CLR]) begin
				tmr_reg[dgtu_pkg::G2_AUX] <= 16'h0000;
			end
			for (int i = 0; i < dgtu_pkg::NUM_TMR; i++) begin
				if (wr_tmr[i]) begin
					tmr_reg[i] <= merge(tmr_reg[i], wb_dat_in, wb_sel_in);
				end
			end
		end
	end

	// Control registers
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			for (int i = 0; i < dgtu_pkg::NUM_TMR; i++) begin
				ctrl_reg[i] <= dgtu_pkg::CTRL_RST;
			end
		end else begin
			for (int i = 0; i < dgtu_pkg::NUM_TMR; i++) begin
				if (wr_ctrl[i]) begin
					ctrl_reg[i] <= merge(ctrl_reg[i], wb_dat_in, wb_sel_in);
				end
			end
		end
	end

	// Capture/reload register
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cap_reg <= dgtu_pkg::TMR_RST;
		end else if (wr_cap) begin
			cap_reg <= merge(cap_reg, wb_dat_in, wb_sel_in);
		end else if (g2_cap) begin
			cap_reg <= tmr_reg[dgtu_pkg::G2_AUX];
		end
	end

	// Toggle latches and their pins
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			core_latch_reg <= 1'b0;
			g2_latch_reg <= 1'b0;
			core_out_reg <= 1'b0;
			g2_out_reg <= 1'b0;
			wrap_out_reg <= 1'b0;
		end else begin
			core_latch_reg <= core_latch_reg ^ wrap[dgtu_pkg::CORE];
			g2_latch_reg <= g2_latch_reg ^ wrap[dgtu_pkg::G2_CORE];
			core_out_reg <= core_latch_reg & ctrl_reg[dgtu_pkg::CORE][dgtu_pkg::F_OE];
			g2_out_reg <= g2_latch_reg & ctrl_reg[dgtu_pkg::G2_CORE][dgtu_pkg::F_OE];
			wrap_out_reg <= wrap[dgtu_pkg::G2_CORE];
		end
	end

	// Sticky event flags, set wins over clear
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			flag_reg <= dgtu_pkg::FLAG_RST;
		end else begin
			flag_reg <= (flag_reg & ~(wr_flag ? wb_dat_in[5:0] : 6'h00))
				| {g2_cap, wrap};
		end
	end

	// Wishbone answer one cycle after request
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ack_reg <= 1'b0;
			rdat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= req;
			if (req) begin
				rdat_reg <= 32'h0000_0000;
				for (int i = 0; i < dgtu_pkg::NUM_TMR; i++) begin
					if (wb_adr_in == dgtu_pkg::OFS_TMR_BASE + 8'(4 * i)) begin
						rdat_reg <= {16'h0000, tmr_reg[i]};
					end
					if (wb_adr_in == dgtu_pkg::OFS_CTRL_BASE + 8'(4 * i)) begin
						rdat_reg <= {16'h0000, ctrl_reg[i]};
					end
				end
				if (wb_adr_in == dgtu_pkg::OFS_CAPTURE_RELOAD_REG) begin
					rdat_reg <= {16'h0000, cap_reg};
				end
				if (wb_adr_in == dgtu_pkg::OFS_FLAG) begin
					rdat_reg <= {26'h0000000, flag_reg};
				end
				if (wb_adr_in == dgtu_pkg::OFS_STAT) begin
					rdat_reg <= {30'h00000000, g2_latch_reg, core_latch_reg};
				end
			end
		end
	end

	assign wb_ack_out = ack_reg;
	assign wb_dat_out = rdat_reg;
	assign core_toggle_output_out = core_out_reg;
	assign group_two_toggle_output_out = g2_out_reg;
	assign group_two_wrap_clock_out = wrap_out_reg;

	property p_latch_toggle;
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		wrap[1] |=> core_latch_reg != $past(core_latch_reg);
	endproperty
	a_latch_toggle: assert property (p_latch_toggle) else $error("core latch missed wrap");

	property p_aux_stop;
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		(ctrl_reg[0][10] && !aux_cap[0] && !wr_tmr[0]) |=> $stable(tmr_reg[0]);
	endproperty
	a_aux_stop: assert property (p_aux_stop) else $error("aux timer counted in role");

	property p_capture;
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		(aux_cap[0] && !wr_tmr[0]) |=> tmr_reg[0] == $past(tmr_reg[1]);
	endproperty
	a_capture: assert property (p_capture) else $error("capture value wrong");

	property p_reload;
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		(aux_rel[0] && !wr_tmr[1]) |=> tmr_reg[1] == $past(tmr_reg[0]);
	endproperty
	a_reload: assert property (p_reload) else $error("reload value wrong");

	property p_overflow;
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		(cnt_en[1] && up[1] && tmr_reg[1] == 16'hFFFF && aux_rel == 2'h0 && !wr_tmr[1])
			|=> tmr_reg[1] == 16'h0000 && flag_reg[1];
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow not to zero");

	property p_g1_res;
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		(tick[1] && ctrl_reg[1][4:3] == 2'h0) |=> !tick[1] [*3];
	endproperty
	a_g1_res: assert property (p_g1_res) else $error("group one tick too fast");

	property p_g2_res;
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		tick[4] |=> !tick[4];
	endproperty
	a_g2_res: assert property (p_g2_res) else $error("group two tick too fast");

	property p_wrap_out;
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		wrap[4] |=> group_two_wrap_clock_out && g2_latch_reg != $past(g2_latch_reg);
	endproperty
	a_wrap_out: assert property (p_wrap_out) else $error("group two wrap lost");

	property p_g2_cap;
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		(g2_cap && !wr_cap) |=> cap_reg == $past(tmr_reg[3]) && flag_reg[5];
	endproperty
	a_g2_cap: assert property (p_g2_cap) else $error("capture register wrong");

	property p_ack;
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		req |=> wb_ack_out ##1 !wb_ack_out;
	endproperty
	a_ack: assert property (p_ack) else $error("bus answer wrong");

	c_pwm: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		aux_rel[0] ##[1:1000] aux_rel[1]);
	c_quad: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		cnt_en[1] && ctrl_reg[1][4:3] == 2'h3);
	c_g2cap: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in) g2_cap);
endmodule : dgtu_top
`default_nettype wire

// ===== verification/dgtu_quad_model.sv
// Quadrature position sensor driving the core count and direction pins
`timescale 1ns/1ps
`default_nettype none
module dgtu_quad_model (
	input  wire logic sys_clk_in,
	input  wire logic reset_n_in,
	input  wire logic step_in,
	input  wire logic down_in,
	output logic      sens_a_out,
	output logic      sens_b_out
);
	logic [1:0] phase_reg;
	// Gray sequence 00,10,11,01 when moving up; one phase per step
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			phase_reg <= 2'h0;
		end else if (step_in) begin
			phase_reg <= down_in ? phase_reg - 2'h1 : phase_reg + 2'h1;
		end
	end
	assign sens_a_out = phase_reg[0] ^ phase_reg[1];
	assign sens_b_out = phase_reg[1];
endmodule : dgtu_quad_model
`default_nettype wire

// ===== verification/test_dual_group_timer_unit.sv
// Self-checking bench for the dual group timer unit
`timescale 1ns/1ps
`default_nettype none
module test_dual_group_timer_unit;
	typedef struct {string nm; logic [31:0] lo; logic [31:0] hi;} dgtu_exp_t;
	logic        sys_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
	logic [7:0]  wb_adr = 8'h00;
	logic [3:0]  wb_sel = 4'hF;
	logic [31:0] wb_dat = 32'h00000000;
	logic [31:0] wb_dat_out;
	logic        wb_ack_out, core_out, g2_out, g2_wrap;
	logic [4:0]  tin = 5'h00;
	logic [3:0]  din = 4'h0;
	logic        cap = 1'b0, q_step = 1'b0, q_down = 1'b0, qa, qb;
	logic [15:0] rnd = 16'hE78A;
	logic [15:0] v;
	dgtu_exp_t   exp_q[$];
	dgtu_exp_t   e;
	int          n_errors = 0, total_checks = 0, cyc_cnt = 0, k, n_g2_wrap = 0;
	always #50 sys_clk = ~sys_clk;
	dgtu_top i_dut (.sys_clk_in(sys_clk), .reset_n_in(reset_n), .wb_cyc_in(wb_cyc),
		.wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel),
		.wb_dat_in(wb_dat), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
		.timer_input_pin_in({tin[4:2], qa, tin[0]}), .direction_input_pin_in({din[3:2], qb, din[0]}),
		.capture_input_pin_in(cap), .core_toggle_output_out(core_out),
		.group_two_toggle_output_out(g2_out), .group_two_wrap_clock_out(g2_wrap));
	dgtu_quad_model i_quad (.sys_clk_in(sys_clk), .reset_n_in(reset_n), .step_in(q_step),
		.down_in(q_down), .sens_a_out(qa), .sens_b_out(qb));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	function automatic logic [7:0] ta(input int t);
		return dgtu_pkg::OFS_TMR_BASE + 8'(4 * t);
	endfunction : ta
	function automatic logic [7:0] ca(input int t);
		return dgtu_pkg::OFS_CTRL_BASE + 8'(4 * t);
	endfunction : ca
	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up
	task automatic bus(input logic we_v, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we_v;
		wb_adr <= a;
		wb_dat <= d;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack_out !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_errors++;
			$display("ERROR ack expected 1 seen 0");
			wrap_up();
		end
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		bus(1'b1, a, {16'h0000, d});
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi,
		input string nm);
		exp_q.push_back('{nm, lo, hi});
		bus(1'b0, a, 32'h00000000);
	endtask : rd
	task automatic pulse(input int i);
		@(posedge sys_clk);
		if (i == 5) cap <= 1'b1; else tin[i] <= 1'b1;
		repeat (6) @(posedge sys_clk);
		if (i == 5) cap <= 1'b0; else tin[i] <= 1'b0;
		repeat (6) @(posedge sys_clk);
	endtask : pulse
	task automatic quad(input int n, input logic dn);
		repeat (n) begin
			@(posedge sys_clk);
			q_step <= 1'b1;
			q_down <= dn;
			@(posedge sys_clk);
			q_step <= 1'b0;
			repeat (8) @(posedge sys_clk);
		end
	endtask : quad
	task automatic chk(input string nm, input logic exp_v, input logic got);
		total_checks++;
		if (got !== exp_v) begin
			n_errors++;
			$display("ERROR %s expected %b seen %b", nm, exp_v, got);
		end
	endtask : chk
	// Read results are matched against the oldest queued expectation
	always @(posedge sys_clk) begin
		if (wb_ack_out === 1'b1 && wb_we === 1'b0) begin
			if (exp_q.size() == 0) begin
				n_errors++;
				$display("ERROR read expected none seen %h", wb_dat_out);
			end else begin
				e = exp_q.pop_front();
				total_checks++;
				if (((wb_dat_out >= e.lo) && (wb_dat_out <= e.hi)) !== 1'b1) begin
					n_errors++;
					$display("ERROR %s expected %h..%h seen %h", e.nm, e.lo, e.hi, wb_dat_out);
				end
			end
		end
	end
	always @(posedge sys_clk) begin
		cyc_cnt++;
		if (cyc_cnt >= 20000) begin
			n_errors++;
			$display("ERROR timeout expected done seen %0d cycles", cyc_cnt);
			wrap_up();
		end
	end
	// Group two wrap clock pulses seen on the pin
	always @(posedge sys_clk) begin
		if (g2_wrap === 1'b1) begin
			n_g2_wrap++;
		end
	end
	initial begin
		repeat (20) @(posedge sys_clk);
		reset_n <= 1'b1;
		for (int a = 0; a < 13; a++) rd(8'(4 * a), 32'h0, 32'h0, "reset value");
		wr(8'h34, 16'hFFFF);
		rd(8'h34, 32'h0, 32'h0, "unmapped");
		wr(dgtu_pkg::OFS_STAT, 16'h0003);
		rd(dgtu_pkg::OFS_STAT, 32'h0, 32'h0, "status read only");
		$display("test reset and map done");
		// 43 cycles of run between the two control writes
		for (int t = 0; t < 2; t++) begin
			for (int n = 0; n < 3; n++) begin
				k = 43 / ((t == 0 ? 4 : 2) << n);
				wr(ta(t == 0 ? dgtu_pkg::CORE : dgtu_pkg::G2_CORE), 16'h0000);
				wr(ca(t == 0 ? dgtu_pkg::CORE : dgtu_pkg::G2_CORE), 16'(32'h20 | n));
				repeat (40) @(posedge sys_clk);
				wr(ca(t == 0 ? dgtu_pkg::CORE : dgtu_pkg::G2_CORE), 16'h0000);
				rd(ta(t == 0 ? dgtu_pkg::CORE : dgtu_pkg::G2_CORE), k - 1, k + 1, "tick count");
			end
		end
		$display("test prescaler done");
		for (int d = 0; d < 2; d++) begin
			wr(ta(dgtu_pkg::CORE), d == 0 ? 16'hFFFE : 16'h0001);
			wr(ca(dgtu_pkg::CORE), d == 0 ? 16'h0420 : 16'h0460);
			repeat (30) @(posedge sys_clk);
			wr(ca(dgtu_pkg::CORE), 16'h0400);
			rd(dgtu_pkg::OFS_STAT, 32'(1 - d), 32'(1 - d), "core latch");
			rd(dgtu_pkg::OFS_FLAG, 32'h2, 32'h2, "wrap flag");
			chk("core toggle pin", 1'(1 - d), core_out);
			wr(dgtu_pkg::OFS_FLAG, 16'h003F);
			rd(dgtu_pkg::OFS_FLAG, 32'h0, 32'h0, "flag clear");
		end
		$display("test wrap and latch done");
		rnd = lfsr(rnd);
		k = rnd % 7 + 1;
		wr(ca(dgtu_pkg::AUX_LOW), 16'h0130);
		repeat (k) pulse(0);
		rd(ta(dgtu_pkg::AUX_LOW), k, k, "counter up");
		din[0] <= 1'b1;
		wr(ca(dgtu_pkg::AUX_LOW), 16'h01B0);
		repeat (k) pulse(0);
		rd(ta(dgtu_pkg::AUX_LOW), 32'h0, 32'h0, "counter pin down");
		din[0] <= 1'b0;
		$display("test counter done");
		rnd = lfsr(rnd);
		v = rnd;
		wr(ca(dgtu_pkg::AUX_LOW), 16'h0000);
		wr(ta(dgtu_pkg::AUX_LOW), v);
		wr(ca(dgtu_pkg::AUX_LOW), 16'h0D30);
		wr(ca(dgtu_pkg::CORE), 16'h0000);
		pulse(0);
		rd(ta(dgtu_pkg::CORE), v, v, "reload core");
		rd(ta(dgtu_pkg::AUX_LOW), v, v, "aux stopped");
		wr(ca(dgtu_pkg::AUX_HIGH), 16'h0530);
		pulse(2);
		rd(ta(dgtu_pkg::AUX_HIGH), v, v, "capture core");
		$display("test capture and reload done");
		wr(ca(dgtu_pkg::AUX_LOW), 16'h0000);
		wr(ca(dgtu_pkg::AUX_HIGH), 16'h0000);
		wr(ta(dgtu_pkg::CORE), 16'h0000);
		wr(ca(dgtu_pkg::CORE), 16'h0338);
		quad(6, 1'b0);
		quad(2, 1'b1);
		rd(ta(dgtu_pkg::CORE), 32'h4, 32'h4, "sensor position");
		wr(ca(dgtu_pkg::CORE), 16'h0000);
		$display("test incremental done");
		rnd = lfsr(rnd);
		v = rnd;
		wr(dgtu_pkg::OFS_FLAG, 16'h003F);
		wr(ta(dgtu_pkg::G2_AUX), v);
		wr(ca(dgtu_pkg::G2_AUX), 16'h0500);
		pulse(5);
		rd(dgtu_pkg::OFS_CAPTURE_RELOAD_REG, v, v, "capture register");
		rd(ta(dgtu_pkg::G2_AUX), 32'h0, 32'h0, "aux cleared");
		rd(dgtu_pkg::OFS_FLAG, 32'h20, 32'h20, "capture flag");
		$display("test group two capture done");
		wr(ta(dgtu_pkg::AUX_HIGH), 16'h0000);
		wr(ca(dgtu_pkg::AUX_HIGH), 16'h0128);
		pulse(2);
		wr(ca(dgtu_pkg::AUX_HIGH), 16'h0000);
		rd(ta(dgtu_pkg::AUX_HIGH), 32'h1, 32'h2, "gated count");
		$display("test gated timer done");
		wr(dgtu_pkg::OFS_FLAG, 16'h003F);
		wr(dgtu_pkg::OFS_CAPTURE_RELOAD_REG, 16'h1000);
		wr(ta(dgtu_pkg::G2_CORE), 16'hFFFE);
		wr(ca(dgtu_pkg::G2_CORE), 16'h0C20);
		repeat (10) @(posedge sys_clk);
		wr(ca(dgtu_pkg::G2_CORE), 16'h0400);
		rd(ta(dgtu_pkg::G2_CORE), 32'h1000, 32'h1006, "reload on wrap");
		rd(dgtu_pkg::OFS_STAT, 32'h2, 32'h2, "group two latch");
		rd(dgtu_pkg::OFS_FLAG, 32'h10, 32'h10, "group two wrap flag");
		chk("group two toggle pin", 1'b1, g2_out);
		chk("wrap clock pulse", 1'b1, n_g2_wrap == 1);
		$display("test group two wrap done");
		@(posedge sys_clk);
		wrap_up();
	end
endmodule : test_dual_group_timer_unit
`default_nettype wire
